/* include/acl_pkg.sv */
package acl_pkg;

    // register byte offsets
    localparam logic [11:0] ACL_OFF_CTRL = 12'h000;
    localparam logic [11:0] ACL_OFF_PROTO = 12'h004;
    localparam logic [11:0] ACL_OFF_SRC_ADDR = 12'h008;
    localparam logic [11:0] ACL_OFF_SRC_MASK = 12'h00c;
    localparam logic [11:0] ACL_OFF_DST_ADDR = 12'h010;
    localparam logic [11:0] ACL_OFF_DST_MASK = 12'h014;
    localparam logic [11:0] ACL_OFF_HITS = 12'h018;
    localparam logic [11:0] ACL_OFF_STATUS = 12'h01c;

    // control word field positions
    localparam int ACL_FT_POS = 0;
    localparam int ACL_ACT_POS = 2;
    localparam int ACL_PM_POS = 3;
    localparam int ACL_TTL_POS = 6;
    localparam int ACL_FRAG_POS = 8;
    localparam int ACL_OPT_POS = 10;
    localparam int ACL_SRC_POS = 12;
    localparam int ACL_DST_POS = 14;
    localparam logic [31:0] ACL_CTRL_MASK = 32'h0000ffff;

    // reset values
    localparam logic [31:0] ACL_CTRL_RST = 32'h00000000;
    localparam logic [31:0] ACL_WORD_RST = 32'h00000000;
    localparam logic [7:0] ACL_PROTO_RST = 8'h00;
    localparam logic [2:0] ACL_STATUS_RST = 3'h0;

    // protocol numbers and header limits
    localparam logic [7:0] ACL_IP_ICMP = 8'h01;
    localparam logic [7:0] ACL_IP_UDP = 8'h11;
    localparam logic [7:0] ACL_IP_TCP = 8'h06;
    localparam logic [3:0] ACL_IHL_MIN = 4'h5;
    localparam logic [7:0] ACL_TTL_ZERO = 8'h00;
    localparam logic [12:0] ACL_FOFF_ZERO = 13'h0000;
    localparam logic [31:0] ACL_HITS_ONE = 32'h00000001;

    // frame type of an entry, also the kind of an ingress frame
    typedef enum logic [1:0] {
        ACL_FT_ANY = 2'h0,
        ACL_FT_ETH = 2'h1,
        ACL_FT_ARP = 2'h2,
        ACL_FT_IPV4 = 2'h3
    } acl_ftype_e;

    // protocol filter modes
    typedef enum logic [2:0] {
        ACL_PM_ANY = 3'h0,
        ACL_PM_SPEC = 3'h1,
        ACL_PM_ICMP = 3'h2,
        ACL_PM_UDP = 3'h3,
        ACL_PM_TCP = 3'h4
    } acl_pmode_e;

    // three-way settings: ttl, fragment, options
    typedef enum logic [1:0] {
        ACL_TRI_ANY = 2'h0,
        ACL_TRI_NO = 2'h1,
        ACL_TRI_YES = 2'h2
    } acl_tri_e;

    // address filter modes
    typedef enum logic [1:0] {
        ACL_AM_ANY = 2'h0,
        ACL_AM_HOST = 2'h1,
        ACL_AM_NET = 2'h2
    } acl_amode_e;

endpackage : acl_pkg

/* include/acl_addr_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface acl_addr_if;
    acl_pkg::acl_amode_e mode;
    logic [31:0] cfg_addr;
    logic [31:0] cfg_mask;
    logic [31:0] frm_addr;
    logic ok;
    modport cmp(input mode, input cfg_addr, input cfg_mask, input frm_addr, output ok);
    modport ctl(output mode, output cfg_addr, output cfg_mask, output frm_addr, input ok);
endinterface : acl_addr_if
`default_nettype wire

/* design/acl_addr_match.sv */
`timescale 1ns/1ps
`default_nettype none
module acl_addr_match (
    // address filter
    acl_addr_if.cmp bus
);
    import acl_pkg::*;

    // host exact, network under mask, any passes
    always_comb begin
        case (bus.mode)
            ACL_AM_ANY: bus.ok = 1'b1; // R10 R13
            ACL_AM_HOST: bus.ok = (bus.frm_addr == bus.cfg_addr); // R11 R14 R16
            ACL_AM_NET: begin
                bus.ok = ((bus.frm_addr & bus.cfg_mask) == (bus.cfg_addr & bus.cfg_mask)); // R12 R15 R16
            end
            default: bus.ok = 1'b0;
        endcase
    end

endmodule : acl_addr_match
`default_nettype wire

/* design/acl_hdr_match.sv */
`timescale 1ns/1ps
`default_nettype none
module acl_hdr_match (
    // entry settings
    input wire acl_pkg::acl_pmode_e pmode,
    input wire logic [7:0] proto_val,
    input wire acl_pkg::acl_tri_e ttl_mode,
    input wire acl_pkg::acl_tri_e frag_mode,
    input wire acl_pkg::acl_tri_e opt_mode,
    // frame header
    input wire logic [7:0] proto,
    input wire logic [7:0] ttl,
    input wire logic mf,
    input wire logic [12:0] frag_off,
    input wire logic [3:0] ihl,
    // per-field pass: {opt, frag, ttl, proto}
    output logic [3:0] ok
);
    import acl_pkg::*;

    logic is_frag;
    logic has_opt;
    logic ttl_pos;

    // header properties
    assign is_frag = mf | (frag_off != ACL_FOFF_ZERO); // R6
    assign has_opt = (ihl > ACL_IHL_MIN); // R8
    assign ttl_pos = (ttl != ACL_TTL_ZERO);

    // protocol field compare
    always_comb begin
        case (pmode)
            ACL_PM_ANY: ok[0] = 1'b1; // R1
            ACL_PM_SPEC: ok[0] = (proto == proto_val); // R2
            ACL_PM_ICMP: ok[0] = (proto == ACL_IP_ICMP); // R3 R20
            ACL_PM_UDP: ok[0] = (proto == ACL_IP_UDP); // R3 R20
            ACL_PM_TCP: ok[0] = (proto == ACL_IP_TCP); // R3 R20
            default: ok[0] = 1'b0;
        endcase
        // ttl, fragment and option compares
        case (ttl_mode)
            ACL_TRI_ANY: ok[1] = 1'b1; // R5
            ACL_TRI_NO: ok[1] = !ttl_pos; // R4
            ACL_TRI_YES: ok[1] = ttl_pos; // R5
            default: ok[1] = 1'b0;
        endcase
        case (frag_mode)
            ACL_TRI_ANY: ok[2] = 1'b1; // R7
            ACL_TRI_NO: ok[2] = !is_frag; // R6
            ACL_TRI_YES: ok[2] = is_frag; // R7
            default: ok[2] = 1'b0;
        endcase
        case (opt_mode)
            ACL_TRI_ANY: ok[3] = 1'b1; // R9
            ACL_TRI_NO: ok[3] = !has_opt; // R8
            ACL_TRI_YES: ok[3] = has_opt; // R9
            default: ok[3] = 1'b0;
        endcase
    end

endmodule : acl_hdr_match
`default_nettype wire

/* design/acl_entry_matcher.sv */
// Function
// R1: protocol don't-care ignores the IPv4 protocol field.
// R2: specific protocol mode matches only frames equal to the 8-bit value.
// R3: ICMP, UDP, TCP selections restrict to that protocol, enable L4 fields.
// R4: ttl zero mode rejects frames with ttl above zero.
// R5: ttl non-zero mode accepts ttl above zero; don't-care ignores ttl.
// R6: fragment no rejects frames with MF set or nonzero offset.
// R7: fragment yes accepts fragmented frames; don't-care ignores fragmentation.
// R8: options no rejects headers longer than minimum.
// R9: options yes accepts frames with options; don't-care ignores them.
// R10: source filter don't-care skips the source address.
// R11: source host mode needs exact source address equality.
// R12: source network mode compares both addresses under the source mask.
// R13: destination filter don't-care skips the destination address.
// R14: destination host mode needs exact destination address equality.
// R15: destination network mode compares only where destination mask is one.
// R16: source mask used only in network mode; address in host and network.
// R17: IPv4 entries match only IPv4 frames; ethernet-type entries exclude IPv4.
// R18: a hit forwards under permit and discards under deny.
// R19: hit counter increments once per matching frame.
// R20: ICMP, UDP, TCP are protocol numbers 1, 17, 6.
// R21: entry hits only when every enabled comparison passes; the code applies the field and address compares to IPv4 entries only.
`timescale 1ns/1ps
`default_nettype none
module acl_entry_matcher (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // parsed ingress header
    input wire logic hdr_valid,
    input wire acl_pkg::acl_ftype_e hdr_kind,
    input wire logic [7:0] hdr_proto,
    input wire logic [7:0] hdr_ttl,
    input wire logic hdr_mf,
    input wire logic [12:0] hdr_frag_off,
    input wire logic [3:0] hdr_ihl,
    input wire logic [31:0] hdr_src,
    input wire logic [31:0] hdr_dst,
    // entry verdict
    output logic res_valid,
    output logic res_hit,
    output logic res_forward,
    output logic res_drop,
    output logic l4_match_en
);
    import acl_pkg::*;

    logic [31:0] ctrl;
    logic [7:0] proto_val;
    logic [31:0] src_addr;
    logic [31:0] src_mask;
    logic [31:0] dst_addr;
    logic [31:0] dst_mask;
    logic [31:0] hits;
    logic [31:0] next_hits;
    logic [2:0] status;
    logic [31:0] next_rdata;
    logic addr_hit;
    logic wr_en;
    logic hits_clr;

    acl_ftype_e cfg_ftype;
    acl_pmode_e cfg_pmode;
    acl_tri_e cfg_ttl;
    acl_tri_e cfg_frag;
    acl_tri_e cfg_opt;
    logic cfg_permit;

    logic [3:0] field_ok;
    logic [1:0] addr_ok;
    logic type_ok;
    logic ip_ok;
    logic next_hit;

    // address filter channels: 0 source, 1 destination
    acl_addr_if aif[2]();

    // control word fields
    assign cfg_ftype = acl_ftype_e'(ctrl[ACL_FT_POS +: 2]);
    assign cfg_permit = ctrl[ACL_ACT_POS];
    assign cfg_pmode = acl_pmode_e'(ctrl[ACL_PM_POS +: 3]);
    assign cfg_ttl = acl_tri_e'(ctrl[ACL_TTL_POS +: 2]);
    assign cfg_frag = acl_tri_e'(ctrl[ACL_FRAG_POS +: 2]);
    assign cfg_opt = acl_tri_e'(ctrl[ACL_OPT_POS +: 2]);

    // protocol selections that open the layer-4 fields
    assign l4_match_en = (cfg_ftype == ACL_FT_IPV4) &&
        ((cfg_pmode == ACL_PM_ICMP) || (cfg_pmode == ACL_PM_UDP) ||
        (cfg_pmode == ACL_PM_TCP)); // R3

    // apb decode, zero wait states
    always_comb begin
        case (paddr)
            ACL_OFF_CTRL: addr_hit = 1'b1;
            ACL_OFF_PROTO: addr_hit = 1'b1;
            ACL_OFF_SRC_ADDR: addr_hit = 1'b1;
            ACL_OFF_SRC_MASK: addr_hit = 1'b1;
            ACL_OFF_DST_ADDR: addr_hit = 1'b1;
            ACL_OFF_DST_MASK: addr_hit = 1'b1;
            ACL_OFF_HITS: addr_hit = 1'b1;
            ACL_OFF_STATUS: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;
    assign wr_en = psel & penable & pwrite & addr_hit;
    assign hits_clr = wr_en && (paddr == ACL_OFF_HITS);

    // read mux, sampled in the setup cycle
    always_comb begin
        case (paddr)
            ACL_OFF_CTRL: next_rdata = ctrl;
            ACL_OFF_PROTO: next_rdata = {24'h000000, proto_val};
            ACL_OFF_SRC_ADDR: next_rdata = src_addr;
            ACL_OFF_SRC_MASK: next_rdata = src_mask;
            ACL_OFF_DST_ADDR: next_rdata = dst_addr;
            ACL_OFF_DST_MASK: next_rdata = dst_mask;
            ACL_OFF_HITS: next_rdata = hits;
            ACL_OFF_STATUS: next_rdata = {29'h00000000, status};
            default: next_rdata = ACL_WORD_RST;
        endcase
    end

    // read data register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= ACL_WORD_RST;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_rdata;
        end
    end

    // entry configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= ACL_CTRL_RST;
            proto_val <= ACL_PROTO_RST;
            src_addr <= ACL_WORD_RST;
            src_mask <= ACL_WORD_RST;
            dst_addr <= ACL_WORD_RST;
            dst_mask <= ACL_WORD_RST;
        end else if (wr_en) begin
            case (paddr)
                ACL_OFF_CTRL: ctrl <= pwdata & ACL_CTRL_MASK;
                ACL_OFF_PROTO: proto_val <= pwdata[7:0];
                ACL_OFF_SRC_ADDR: src_addr <= pwdata;
                ACL_OFF_SRC_MASK: src_mask <= pwdata;
                ACL_OFF_DST_ADDR: dst_addr <= pwdata;
                ACL_OFF_DST_MASK: dst_mask <= pwdata;
                default: ;
            endcase
        end
    end

    // address filter wiring
    assign aif[0].mode = acl_amode_e'(ctrl[ACL_SRC_POS +: 2]);
    assign aif[0].cfg_addr = src_addr;
    assign aif[0].cfg_mask = src_mask;
    assign aif[0].frm_addr = hdr_src;
    assign aif[1].mode = acl_amode_e'(ctrl[ACL_DST_POS +: 2]);
    assign aif[1].cfg_addr = dst_addr;
    assign aif[1].cfg_mask = dst_mask;
    assign aif[1].frm_addr = hdr_dst;

    // one comparator per address channel
    for (genvar gi = 0; gi < 2; gi++) begin : g_addr
        acl_addr_match u_addr (
            .bus(aif[gi].cmp)
        );
        assign addr_ok[gi] = aif[gi].ok;
    end

    // protocol, ttl, fragment and option compares
    acl_hdr_match u_hdr (
        .pmode(cfg_pmode),
        .proto_val(proto_val),
        .ttl_mode(cfg_ttl),
        .frag_mode(cfg_frag),
        .opt_mode(cfg_opt),
        .proto(hdr_proto),
        .ttl(hdr_ttl),
        .mf(hdr_mf),
        .frag_off(hdr_frag_off),
        .ihl(hdr_ihl),
        .ok(field_ok)
    );

    // frame type gate
    always_comb begin
        case (cfg_ftype)
            ACL_FT_ANY: type_ok = 1'b1;
            ACL_FT_ETH: type_ok = (hdr_kind == ACL_FT_ETH); // R17
            ACL_FT_ARP: type_ok = (hdr_kind == ACL_FT_ARP);
            ACL_FT_IPV4: type_ok = (hdr_kind == ACL_FT_IPV4); // R17
            default: type_ok = 1'b0;
        endcase
    end

    // ip fields count only for ipv4 entries
    assign ip_ok = (cfg_ftype != ACL_FT_IPV4) || ((&field_ok) && (&addr_ok)); // R21
    assign next_hit = type_ok && ip_ok; // R21

    // verdict register, one cycle after the header
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid <= 1'b0;
            res_hit <= 1'b0;
            res_forward <= 1'b0;
            res_drop <= 1'b0;
        end else begin
            res_valid <= hdr_valid;
            res_hit <= hdr_valid && next_hit;
            res_forward <= hdr_valid && next_hit && cfg_permit; // R18
            res_drop <= hdr_valid && next_hit && !cfg_permit; // R18
        end
    end

    // hit count, a hit in the clearing cycle still counts
    always_comb begin
        next_hits = hits_clr ? ACL_WORD_RST : hits;
        if (hdr_valid && next_hit) begin
            next_hits = next_hits + ACL_HITS_ONE; // R19
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hits <= ACL_WORD_RST;
        end else begin
            hits <= next_hits; // R19
        end
    end

    // last verdict for software: {valid, forward, hit}
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= ACL_STATUS_RST;
        end else if (hdr_valid) begin
            status <= {1'b1, next_hit && cfg_permit, next_hit};
        end
    end

    // checks on the field compares
    AST_PROTO_ANY: assert property (@(posedge pclk) disable iff (!presetn) // R1
        (cfg_pmode == ACL_PM_ANY) |-> field_ok[0])
        else $error("protocol don't-care did not pass");

    AST_PROTO_SPEC: assert property (@(posedge pclk) disable iff (!presetn) // R2
        (cfg_pmode == ACL_PM_SPEC) |-> (field_ok[0] == (hdr_proto == proto_val)))
        else $error("specific protocol compare wrong");

    AST_PROTO_NUM: assert property (@(posedge pclk) disable iff (!presetn) // R20
        (cfg_pmode == ACL_PM_UDP) |-> (field_ok[0] == (hdr_proto == 8'h11)))
        else $error("udp selection uses wrong protocol number");

    AST_TTL_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R4
        hdr_valid && (cfg_ftype == ACL_FT_IPV4) && (cfg_ttl == ACL_TRI_NO) &&
        (hdr_ttl != 8'h00) |=> !res_hit)
        else $error("frame with ttl above zero hit a zero-ttl entry");

    AST_TTL_NONZERO: assert property (@(posedge pclk) disable iff (!presetn) // R5
        (cfg_ttl == ACL_TRI_YES) |-> (field_ok[1] == (hdr_ttl != 8'h00)))
        else $error("non-zero ttl compare wrong");

    AST_FRAG_NO: assert property (@(posedge pclk) disable iff (!presetn) // R6
        (cfg_frag == ACL_TRI_NO) && (hdr_mf || (hdr_frag_off != 13'h0000))
        |-> !field_ok[2])
        else $error("fragment passed a no-fragment entry");

    AST_OPT_NO: assert property (@(posedge pclk) disable iff (!presetn) // R8
        (cfg_opt == ACL_TRI_NO) |-> (field_ok[3] == (hdr_ihl <= 4'h5)))
        else $error("option compare wrong");

    AST_SRC_NET: assert property (@(posedge pclk) disable iff (!presetn) // R12
        (aif[0].mode == ACL_AM_NET) |->
        (addr_ok[0] == (((hdr_src ^ src_addr) & src_mask) == 32'h00000000)))
        else $error("source network compare wrong");

    AST_DST_HOST: assert property (@(posedge pclk) disable iff (!presetn) // R14
        (aif[1].mode == ACL_AM_HOST) |-> (addr_ok[1] == (hdr_dst == dst_addr)))
        else $error("destination host compare wrong");

    AST_FRAG_YES: assert property (@(posedge pclk) disable iff (!presetn) // R7
        (cfg_frag == ACL_TRI_YES) |-> (field_ok[2] == (hdr_mf || (hdr_frag_off != 13'h0000))))
        else $error("fragment yes compare wrong");

    AST_OPT_YES: assert property (@(posedge pclk) disable iff (!presetn) // R9
        (cfg_opt == ACL_TRI_YES) |-> (field_ok[3] == (hdr_ihl > 4'h5)))
        else $error("option yes compare wrong");

    AST_PROTO_ICMP: assert property (@(posedge pclk) disable iff (!presetn) // R20
        (cfg_pmode == ACL_PM_ICMP) |-> (field_ok[0] == (hdr_proto == 8'h01)))
        else $error("icmp protocol number wrong");

    AST_PROTO_TCP: assert property (@(posedge pclk) disable iff (!presetn) // R20
        (cfg_pmode == ACL_PM_TCP) |-> (field_ok[0] == (hdr_proto == 8'h06)))
        else $error("tcp protocol number wrong");

    AST_SRC_HOST: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (aif[0].mode == ACL_AM_HOST) |-> (addr_ok[0] == (hdr_src == src_addr)))
        else $error("source host compare wrong");

    AST_DST_NET: assert property (@(posedge pclk) disable iff (!presetn) // R15
        (aif[1].mode == ACL_AM_NET) |->
        (addr_ok[1] == (((hdr_dst ^ dst_addr) & dst_mask) == 32'h00000000)))
        else $error("destination network compare wrong");

    AST_RES_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // R18
        (res_hit || res_forward || res_drop) |-> res_valid)
        else $error("verdict without a valid pulse");

    // checks on the verdict
    AST_FTYPE: assert property (@(posedge pclk) disable iff (!presetn) // R17
        hdr_valid && (hdr_kind == ACL_FT_IPV4) && (cfg_ftype == ACL_FT_ETH)
        |=> res_valid && !res_hit)
        else $error("ipv4 frame hit an ethernet-type entry");

    AST_ALL_FIELDS: assert property (@(posedge pclk) disable iff (!presetn) // R21
        hdr_valid && (cfg_ftype == ACL_FT_IPV4) && !((&field_ok) && (&addr_ok))
        |=> !res_hit && !res_forward && !res_drop)
        else $error("entry hit with a failing field");

    AST_ACTION: assert property (@(posedge pclk) disable iff (!presetn) // R18
        res_hit |-> (res_forward != res_drop) && (res_forward == $past(cfg_permit)))
        else $error("hit verdict does not follow the action");

    AST_HIT_COUNT: assert property (@(posedge pclk) disable iff (!presetn) // R19
        hdr_valid && next_hit && !hits_clr |=> (hits == $past(hits) + 32'h00000001))
        else $error("hit counter did not advance by one");

    AST_NO_HIT_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R19
        !(hdr_valid && next_hit) && !hits_clr |=> $stable(hits))
        else $error("hit counter moved without a hit");

endmodule : acl_entry_matcher
`default_nettype wire

/* dv/acl_hdr_src.sv */
`timescale 1ns/1ps
`default_nettype none
module acl_hdr_src (
    // clock
    input wire logic pclk,
    // parsed header toward the entry
    output logic hdr_valid,
    output acl_pkg::acl_ftype_e hdr_kind,
    output logic [7:0] hdr_proto,
    output logic [7:0] hdr_ttl,
    output logic hdr_mf,
    output logic [12:0] hdr_frag_off,
    output logic [3:0] hdr_ihl,
    output logic [31:0] hdr_src,
    output logic [31:0] hdr_dst
);
    import acl_pkg::*;

    // quiet port before the first header
    initial begin
        hdr_valid = 1'b0;
        hdr_kind = ACL_FT_ANY;
        {hdr_proto, hdr_ttl, hdr_mf, hdr_frag_off, hdr_ihl, hdr_src, hdr_dst} = '0;
    end

    // one header per cycle for n cycles; afterwards the fields drift to their inverse
    task automatic send(input int n, input acl_ftype_e k, input logic [7:0] p,
        input logic [7:0] t, input logic m, input logic [12:0] fo, input logic [3:0] ih,
        input logic [31:0] s, input logic [31:0] d);
        repeat (n) begin
            @(posedge pclk);
            hdr_valid <= 1'b1;
            hdr_kind <= k;
            {hdr_proto, hdr_ttl, hdr_mf, hdr_frag_off, hdr_ihl, hdr_src, hdr_dst}
                <= {p, t, m, fo, ih, s, d};
        end
        @(posedge pclk);
        hdr_valid <= 1'b0;
        hdr_kind <= acl_ftype_e'(~k);
        {hdr_proto, hdr_ttl, hdr_mf, hdr_frag_off, hdr_ihl, hdr_src, hdr_dst}
            <= ~{p, t, m, fo, ih, s, d};
    endtask : send
endmodule : acl_hdr_src
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import acl_pkg::*;
    localparam logic [31:0] SA = 32'hc0a80101;
    localparam logic [31:0] SM = 32'hffffff00;
    localparam logic [31:0] DA = 32'h0a000001;
    localparam logic [31:0] DM = 32'hff000000;
    typedef struct {logic [31:0] c; int f; logic [31:0] v; logic h;} acl_row_s;
    // bench signals
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic hdr_valid, hdr_mf, res_valid, res_hit, res_forward, res_drop, l4_match_en;
    acl_ftype_e hdr_kind;
    logic [7:0] hdr_proto, hdr_ttl;
    logic [12:0] hdr_frag_off;
    logic [3:0] hdr_ihl;
    logic [31:0] hdr_src, hdr_dst;
    int err_total, comparisons;
    acl_row_s rows[$];

    acl_entry_matcher dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .hdr_valid, .hdr_kind, .hdr_proto, .hdr_ttl, .hdr_mf,
        .hdr_frag_off, .hdr_ihl, .hdr_src, .hdr_dst, .res_valid, .res_hit, .res_forward,
        .res_drop, .l4_match_en);
    acl_hdr_src src_u (.pclk, .hdr_valid, .hdr_kind, .hdr_proto, .hdr_ttl, .hdr_mf,
        .hdr_frag_off, .hdr_ihl, .hdr_src, .hdr_dst);

    // 50 MHz clock
    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    // verdict and end of run
    task automatic test_done;
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done

    // word comparison
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    // one apb transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // control word for an ipv4 permit entry
    function automatic logic [31:0] cw(input logic [2:0] pm, input logic [1:0] tt,
        input logic [1:0] fr, input logic [1:0] op, input logic [1:0] sa, input logic [1:0] da);
        return {16'h0000, da, sa, op, fr, tt, pm, 1'b1, 2'h3};
    endfunction : cw

    task automatic r(input logic [31:0] c, input int f, input logic [31:0] v, input logic h);
        rows.push_back('{c, f, v, h});
    endtask : r

    // base ipv4 header with one field replaced, sent n times back to back
    task automatic go(input int n, input int f, input logic [31:0] v);
        acl_ftype_e k;
        logic [7:0] p, t;
        logic m;
        logic [12:0] fo;
        logic [3:0] ih;
        logic [31:0] s, d;
        k = ACL_FT_IPV4;
        p = 8'h2f;
        t = 8'h40;
        m = 1'b0;
        fo = ACL_FOFF_ZERO;
        ih = ACL_IHL_MIN;
        s = SA;
        d = DA;
        case (f)
            1: p = v[7:0];
            2: t = v[7:0];
            3: m = v[0];
            4: fo = v[12:0];
            5: ih = v[3:0];
            6: s = v;
            7: d = v;
            8: k = acl_ftype_e'(v[1:0]);
            default: ;
        endcase
        src_u.send(n, k, p, t, m, fo, ih, s, d);
        #1;
    endtask : go

    // watchdog
    initial begin
        #200000;
        err_total++;
        test_done();
    end

    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        err_total = 0;
        comparisons = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ACL_OFF_CTRL, 32'h0);
        chk(rd, ACL_CTRL_RST);
        chk(err, 32'h0);
        apb(1'b0, ACL_OFF_HITS, 32'h0);
        chk(rd, ACL_WORD_RST);
        apb(1'b1, ACL_OFF_PROTO, 32'h2f);
        apb(1'b1, ACL_OFF_SRC_ADDR, SA);
        apb(1'b1, ACL_OFF_SRC_MASK, SM);
        apb(1'b1, ACL_OFF_DST_ADDR, DA);
        apb(1'b1, ACL_OFF_DST_MASK, DM);
        apb(1'b0, ACL_OFF_PROTO, 32'h0);
        chk(rd, 32'h2f);
        r(cw(0, 0, 0, 0, 0, 0), 0, 32'h0, 1'b1);
        r(cw(0, 0, 0, 0, 0, 0), 1, 32'hff, 1'b1);
        r(cw(1, 0, 0, 0, 0, 0), 0, 32'h0, 1'b1);
        r(cw(1, 0, 0, 0, 0, 0), 1, 32'h2e, 1'b0);
        r(cw(2, 0, 0, 0, 0, 0), 1, 32'h01, 1'b1);
        r(cw(2, 0, 0, 0, 0, 0), 1, 32'h11, 1'b0);
        r(cw(3, 0, 0, 0, 0, 0), 1, 32'h11, 1'b1);
        r(cw(3, 0, 0, 0, 0, 0), 1, 32'h06, 1'b0);
        r(cw(4, 0, 0, 0, 0, 0), 1, 32'h06, 1'b1);
        r(cw(4, 0, 0, 0, 0, 0), 0, 32'h0, 1'b0);
        r(cw(0, 1, 0, 0, 0, 0), 2, 32'h00, 1'b1);
        r(cw(0, 1, 0, 0, 0, 0), 2, 32'h01, 1'b0);
        r(cw(0, 2, 0, 0, 0, 0), 2, 32'hff, 1'b1);
        r(cw(0, 0, 0, 0, 0, 0), 2, 32'h00, 1'b1);
        r(cw(0, 0, 1, 0, 0, 0), 3, 32'h1, 1'b0);
        r(cw(0, 0, 1, 0, 0, 0), 4, 32'h1, 1'b0);
        r(cw(0, 0, 1, 0, 0, 0), 0, 32'h0, 1'b1);
        r(cw(0, 0, 2, 0, 0, 0), 3, 32'h1, 1'b1);
        r(cw(0, 0, 0, 0, 0, 0), 4, 32'h1fff, 1'b1);
        r(cw(0, 0, 0, 1, 0, 0), 5, 32'h6, 1'b0);
        r(cw(0, 0, 0, 1, 0, 0), 0, 32'h0, 1'b1);
        r(cw(0, 0, 0, 2, 0, 0), 5, 32'hf, 1'b1);
        r(cw(0, 0, 0, 0, 0, 0), 5, 32'hf, 1'b1);
        r(cw(0, 0, 0, 0, 0, 0), 6, 32'h0, 1'b1);
        r(cw(0, 0, 0, 0, 1, 0), 0, 32'h0, 1'b1);
        r(cw(0, 0, 0, 0, 1, 0), 6, 32'hc0a80102, 1'b0);
        r(cw(0, 0, 0, 0, 2, 0), 6, 32'hc0a801fe, 1'b1);
        r(cw(0, 0, 0, 0, 2, 0), 6, 32'hc0a802fe, 1'b0);
        r(cw(0, 0, 0, 0, 0, 0), 7, 32'h0, 1'b1);
        r(cw(0, 0, 0, 0, 0, 1), 0, 32'h0, 1'b1);
        r(cw(0, 0, 0, 0, 0, 1), 7, 32'h0a000002, 1'b0);
        r(cw(0, 0, 0, 0, 0, 2), 7, 32'h0affffff, 1'b1);
        r(cw(0, 0, 0, 0, 0, 2), 7, 32'h0b000001, 1'b0);
        r(cw(0, 0, 0, 0, 0, 0), 8, 32'h1, 1'b0);
        r(cw(1, 2, 1, 1, 1, 1), 0, 32'h0, 1'b1);
        r(cw(1, 2, 1, 1, 1, 1), 7, 32'h0a000003, 1'b0);
        foreach (rows[i]) begin
            apb(1'b1, ACL_OFF_CTRL, rows[i].c);
            go(1, rows[i].f, rows[i].v);
            chk(l4_match_en, rows[i].c[5:3] inside {3'h2, 3'h3, 3'h4});
            chk(res_valid, 32'h1);
            chk(res_hit, rows[i].h);
            chk(res_forward, rows[i].h);
        end
        // deny entry drops a hit
        apb(1'b1, ACL_OFF_CTRL, 32'h3);
        go(1, 0, 32'h0);
        chk({res_hit, res_forward, res_drop}, 32'h5);
        // ethernet-type entry refuses ipv4 and arp frames
        apb(1'b1, ACL_OFF_CTRL, 32'h5);
        go(1, 0, 32'h0);
        chk(res_hit, 32'h0);
        go(1, 8, 32'h2);
        chk(res_hit, 32'h0);
        go(1, 8, 32'h1);
        chk(res_hit, 32'h1);
        // counter clears, then counts back-to-back hits only
        apb(1'b1, ACL_OFF_CTRL, 32'h7);
        apb(1'b1, ACL_OFF_HITS, 32'h0);
        go(3, 0, 32'h0);
        go(1, 8, 32'h1);
        apb(1'b0, ACL_OFF_HITS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, ACL_OFF_STATUS, 32'hffffffff);
        apb(1'b0, ACL_OFF_STATUS, 32'h0);
        chk(rd, 32'h4);
        // upper control bits read as zero
        apb(1'b1, ACL_OFF_CTRL, 32'hffffffff);
        apb(1'b0, ACL_OFF_CTRL, 32'h0);
        chk(rd, ACL_CTRL_MASK);
        // reset in mid-run, then any-type and arp-type entries
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ACL_OFF_CTRL, 32'h0);
        chk(rd, ACL_CTRL_RST);
        apb(1'b0, ACL_OFF_HITS, 32'h0);
        chk(rd, ACL_WORD_RST);
        go(1, 0, 32'h0);
        chk({res_hit, res_forward, res_drop}, 32'h5);
        apb(1'b1, ACL_OFF_CTRL, 32'h6);
        go(1, 8, 32'h2);
        chk(res_hit, 32'h1);
        go(1, 0, 32'h0);
        chk(res_hit, 32'h0);
        // unmapped address
        apb(1'b0, 12'h020, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
